//--- rtl/rmasu_core.v
// Real-mode address formation and stack sequencing unit with a classic
// Wishbone register slave and a 16-bit memory master port.
// Assumes the memory port answers on sys_clk_in; the mask pin is async.
// Functional notes
// - Base is selector shifted left four bits; offset added gives linear address.
// - Selectors are used directly as bases, never as table indexes.
// - Carry beyond one megabyte is kept in the physical address.
// - Mask input low forces bit 20 of translated and stack addresses to zero, not of table reads; system drives it consistently.
// - Prefixed 32-bit offset above FFFFH raises fault vector 12 or 13.
// - Segments span 64 KB; operands use 16-bit offsets.
// - Instruction pointer is low half of the 32-bit extended pointer.
// - Visible flags are the low sixteen bits of extended flags.
// - One 16-bit stack in stack segment, growing downward per push.
// - Calls push instruction pointer; far calls push code selector too.
// - Returns pop instruction pointer; far returns pop code selector too.
// - Handler entry pushes pointer, code selector and low 16 flag bits.
// - Interrupt return pops pointer, code selector and flags.
// - Handlers found through a table of 4-byte entries by vector.
// - Load-table-base command relocates the interrupt table.
// - Operand-size prefix gives 32-bit register access.
// - Address-size prefix gives 32-bit offsets, range checked.
// - Without prefixes operands are 8-bit or 16-bit.
// - Eight 16-bit registers, each the low half of a 32-bit one.
// - Two extra data segment selectors beyond the usual four.
// - Real-address mode is entered on every reset.
// - After reset table base is zero and limit 3FFH.
// - Vector number times four is the table byte offset.
// - Handler entry clears interrupt enable after saving state.
//
// Chosen here: the Wishbone slave port and the register offsets.
`include "rmasu_map.vh"

module rmasu_core (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    input wire addr_bit20_mask_n_in,
    output reg mem_req_out,
    output reg mem_we_out,
    output reg [31:0] mem_addr_out,
    output reg [15:0] mem_wdata_out,
    input wire mem_ack_in,
    input wire [15:0] mem_rdata_in,
    output reg busy_out
);

    localparam ST_IDLE = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_ISSUE = 2'h2;
    localparam ST_WAIT = 2'h3;

    localparam K_NONE = 2'h0;
    localparam K_PUSH = 2'h1;
    localparam K_POP = 2'h2;
    localparam K_TABLE = 2'h3;

    localparam S_IP = 2'h0;
    localparam S_CS = 2'h1;
    localparam S_FL = 2'h2;

    reg [31:0] gpr_reg [0:7];
    reg [15:0] seg_reg [0:5];
    reg [31:0] instr_pointer_ext_reg;
    reg [31:0] flags_ext_reg;
    reg [31:0] idt_base_reg;
    reg [15:0] idt_limit_reg;
    reg [31:0] ctrl_reg;
    reg [31:0] xlat_off_reg;
    reg [31:0] linear_reg;
    reg [31:0] tgt_off_reg;
    reg [15:0] tgt_seg_reg;
    reg fault_reg;
    reg [7:0] fault_vec_reg;
    reg [1:0] state_reg;
    reg [2:0] step_reg;
    reg [1:0] dst_reg;
    reg [1:0] kind_reg;
    reg mask_meta_reg;
    reg mask_sync_reg;
    reg [31:0] rd_next;
    reg [1:0] mc_kind_next;
    reg [1:0] mc_sel_next;
    reg [1:0] mc_toff_next;
    integer i;

    wire [3:0] op = ctrl_reg[3:0];
    wire [7:0] vec = ctrl_reg[15:8];
    wire [2:0] xl_idx = ctrl_reg[18:16];
    wire opsize = ctrl_reg[`RMASU_CTRL_OPSIZE];
    wire addrsize = ctrl_reg[`RMASU_CTRL_ADDRSIZE];
    wire [15:0] sp_now = gpr_reg[`RMASU_GPR_SP][15:0];
    wire [15:0] sp_dec = sp_now - 16'h0002;
    wire [15:0] sp_inc = sp_now + 16'h0002;
    wire [15:0] xl_seg = (xl_idx > 3'h5) ? 16'h0000 : seg_reg[xl_idx];
    wire [17:0] vec_off = {8'h00, vec, 2'h0};
    wire [17:0] vec_top = vec_off + 18'h00003;
    wire wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire [2:0] gpr_idx = wb_adr_in[4:2];
    wire gpr_hit = (wb_adr_in[7:5] == 3'h4);
    wire [2:0] seg_idx = wb_adr_in[4:2] - 3'h4;
    wire seg_hit = (wb_adr_in >= `RMASU_OFF_SEG) && (wb_adr_in < `RMASU_OFF_IDT_BASE);

    // Selector is used as a plain base, never a descriptor index.
    // The adder keeps 21 bits so the carry out of bit 19 survives.
    function [31:0] phys;
        input [15:0] sel;
        input [15:0] off;
        input mask_on;
        reg [20:0] sum;
        begin
            sum = {1'b0, sel, 4'h0} + {5'h00, off};
            if (mask_on)
                sum[20] = 1'b0;
            phys = {11'h000, sum};
        end
    endfunction

    // Merges bus write data into a register by byte lane.
    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer b;
        begin
            be_merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (sel[b])
                    be_merge[b*8 +: 8] = nw[b*8 +: 8];
        end
    endfunction

    // Step table of each stack sequence: access kind, data source or sink,
    // and table word offset.
    always @*
    begin
        mc_kind_next = K_NONE;
        mc_sel_next = S_IP;
        mc_toff_next = 2'h0;
        case (op)
            `RMASU_OP_NCALL:
                if (step_reg == 3'h0)
                    mc_kind_next = K_PUSH;
            `RMASU_OP_FCALL:
            begin
                // Selector first, then the pointer.
                if (step_reg < 3'h2)
                    mc_kind_next = K_PUSH;
                if (step_reg == 3'h0)
                    mc_sel_next = S_CS;
            end
            `RMASU_OP_NRET:
                if (step_reg == 3'h0)
                    mc_kind_next = K_POP;
            `RMASU_OP_FRET:
            begin
                if (step_reg < 3'h2)
                    mc_kind_next = K_POP;
                if (step_reg == 3'h1)
                    mc_sel_next = S_CS;
            end
            `RMASU_OP_INT:
            begin
                // Flags go first so the return pops them last.
                if (step_reg < 3'h3)
                begin
                    mc_kind_next = K_PUSH;
                    mc_sel_next = (step_reg == 3'h0) ? S_FL :
                        ((step_reg == 3'h1) ? S_CS : S_IP);
                end
                else if (step_reg < 3'h5)
                begin
                    mc_kind_next = K_TABLE;
                    mc_sel_next = (step_reg == 3'h3) ? S_IP : S_CS;
                    mc_toff_next = (step_reg == 3'h3) ? 2'h0 : 2'h2;
                end
            end
            `RMASU_OP_INT_RETURN_INSTR:
                if (step_reg < 3'h3)
                begin
                    mc_kind_next = K_POP;
                    mc_sel_next = (step_reg == 3'h0) ? S_IP :
                        ((step_reg == 3'h1) ? S_CS : S_FL);
                end
            default:
                mc_kind_next = K_NONE;
        endcase
    end

    // Register read multiplexer; unmapped offsets read as zero.
    always @*
    begin
        rd_next = 32'h00000000;
        // Without the size prefix only the low half is seen.
        if (gpr_hit)
            rd_next = opsize ? gpr_reg[gpr_idx] : {16'h0000, gpr_reg[gpr_idx][15:0]};
        else if (seg_hit)
            rd_next = {16'h0000, seg_reg[seg_idx]};
        else
            case (wb_adr_in)
                `RMASU_OFF_CTRL: rd_next = ctrl_reg;
                `RMASU_OFF_STATUS: rd_next = {16'h0000, fault_vec_reg, 5'h00, 1'b1,
                    fault_reg, busy_out};
                `RMASU_OFF_EIP: rd_next = instr_pointer_ext_reg;
                `RMASU_OFF_FLAGS_EXT: rd_next = flags_ext_reg;
                `RMASU_OFF_IDT_BASE: rd_next = idt_base_reg;
                `RMASU_OFF_IDT_LIMIT: rd_next = {16'h0000, idt_limit_reg};
                `RMASU_OFF_XLAT_OFF: rd_next = xlat_off_reg;
                `RMASU_OFF_LINEAR: rd_next = linear_reg;
                `RMASU_OFF_TGT_OFF: rd_next = tgt_off_reg;
                `RMASU_OFF_TGT_SEG: rd_next = {16'h0000, tgt_seg_reg};
                default: rd_next = 32'h00000000;
            endcase
    end

    // Bus slave, architectural state and sequencer share one process so
    // each register has a single driver; bus writes other than the fault clear are held off while busy.
    always @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (i = 0; i < 8; i = i + 1)
                gpr_reg[i] <= 32'h00000000;
            for (i = 0; i < 6; i = i + 1)
                seg_reg[i] <= 16'h0000;
            instr_pointer_ext_reg <= 32'h00000000;
            flags_ext_reg <= `RMASU_RST_FLAGS_EXT;
            idt_base_reg <= `RMASU_RST_IDT_BASE;
            idt_limit_reg <= `RMASU_RST_IDT_LIMIT;
            ctrl_reg <= 32'h00000000;
            xlat_off_reg <= 32'h00000000;
            linear_reg <= 32'h00000000;
            tgt_off_reg <= 32'h00000000;
            tgt_seg_reg <= 16'h0000;
            fault_reg <= 1'b0;
            fault_vec_reg <= 8'h00;
            state_reg <= ST_IDLE;
            step_reg <= 3'h0;
            dst_reg <= S_IP;
            kind_reg <= K_NONE;
            mask_meta_reg <= 1'b0;
            mask_sync_reg <= 1'b0;
            wb_dat_out <= 32'h00000000;
            wb_ack_out <= 1'b0;
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_addr_out <= 32'h00000000;
            mem_wdata_out <= 16'h0000;
            busy_out <= 1'b0;
        end
        else
        begin
            // The mask pin is asynchronous; two flops before use.
            mask_meta_reg <= !addr_bit20_mask_n_in;
            mask_sync_reg <= mask_meta_reg;
            busy_out <= (state_reg != ST_IDLE) || (wb_hit && wb_we_in &&
                wb_adr_in == `RMASU_OFF_CTRL && !busy_out && wb_sel_in[0] &&
                wb_dat_in[3:0] != `RMASU_OP_NONE);
            wb_ack_out <= wb_hit;
            if (wb_hit)
                wb_dat_out <= rd_next;
            if (wb_hit && wb_we_in)
            begin
                if (wb_adr_in == `RMASU_OFF_STATUS && wb_sel_in[0] && wb_dat_in[1])
                    fault_reg <= 1'b0;
                else if (!busy_out && gpr_hit)
                    gpr_reg[gpr_idx] <= be_merge(gpr_reg[gpr_idx], wb_dat_in,
                        opsize ? wb_sel_in : {2'h0, wb_sel_in[1:0]});
                else if (!busy_out && seg_hit)
                    seg_reg[seg_idx] <= wb_dat_in[15:0];
                else if (!busy_out)
                begin
                    case (wb_adr_in)
                        `RMASU_OFF_CTRL:
                        begin
                            ctrl_reg <= be_merge(ctrl_reg, wb_dat_in, wb_sel_in);
                            if (wb_sel_in[0] && wb_dat_in[3:0] != `RMASU_OP_NONE)
                                state_reg <= ST_START;
                        end
                        `RMASU_OFF_EIP: instr_pointer_ext_reg <=
                            be_merge(instr_pointer_ext_reg, wb_dat_in, wb_sel_in);
                        `RMASU_OFF_FLAGS_EXT: flags_ext_reg <=
                            be_merge(flags_ext_reg, wb_dat_in, wb_sel_in);
                        `RMASU_OFF_XLAT_OFF: xlat_off_reg <=
                            be_merge(xlat_off_reg, wb_dat_in, wb_sel_in);
                        `RMASU_OFF_TGT_OFF: tgt_off_reg <=
                            be_merge(tgt_off_reg, wb_dat_in, wb_sel_in);
                        `RMASU_OFF_TGT_SEG: tgt_seg_reg <= wb_dat_in[15:0];
                        default: ;
                    endcase
                end
            end

            // Sequencer. Fault setting comes after the bus clear so set wins.
            case (state_reg)
                ST_START:
                begin
                    step_reg <= 3'h0;
                    state_reg <= ST_IDLE;
                    case (op)
                        `RMASU_OP_XLAT:
                        begin
                            // Offsets are 16 bits unless the address prefix
                            // widens them; then the upper half must be zero.
                            if (addrsize && xlat_off_reg[31:16] != 16'h0000)
                            begin
                                fault_reg <= 1'b1;
                                fault_vec_reg <= (xl_idx == `RMASU_SEG_SS) ?
                                    `RMASU_VEC_STACK_FAULT : `RMASU_VEC_GP_FAULT;
                            end
                            else
                                linear_reg <= phys(xl_seg, xlat_off_reg[15:0],
                                    mask_sync_reg);
                        end
                        `RMASU_OP_LOAD_INT_TABLE_BASE_INSTR:
                        begin
                            idt_base_reg <= tgt_off_reg;
                            idt_limit_reg <= tgt_seg_reg;
                        end
                        `RMASU_OP_INT:
                        begin
                            // An entry beyond the table limit is refused.
                            if (vec_top > {2'h0, idt_limit_reg})
                            begin
                                fault_reg <= 1'b1;
                                fault_vec_reg <= `RMASU_VEC_GP_FAULT;
                            end
                            else
                                state_reg <= ST_ISSUE;
                        end
                        `RMASU_OP_NCALL, `RMASU_OP_FCALL, `RMASU_OP_NRET,
                        `RMASU_OP_FRET, `RMASU_OP_INT_RETURN_INSTR:
                            state_reg <= ST_ISSUE;
                        default: ;
                    endcase
                end
                ST_ISSUE:
                begin
                    kind_reg <= mc_kind_next;
                    dst_reg <= mc_sel_next;
                    mem_we_out <= (mc_kind_next == K_PUSH);
                    case (mc_kind_next)
                        K_PUSH:
                        begin
                            // Stack grows down: decrement, then store.
                            gpr_reg[`RMASU_GPR_SP][15:0] <= sp_dec;
                            mem_addr_out <= phys(seg_reg[`RMASU_SEG_SS], sp_dec,
                                mask_sync_reg);
                            mem_wdata_out <= (mc_sel_next == S_CS) ? seg_reg[`RMASU_SEG_CS] :
                                ((mc_sel_next == S_FL) ? flags_ext_reg[15:0] :
                                instr_pointer_ext_reg[15:0]);
                            mem_req_out <= 1'b1;
                            state_reg <= ST_WAIT;
                        end
                        K_POP:
                        begin
                            mem_addr_out <= phys(seg_reg[`RMASU_SEG_SS], sp_now,
                                mask_sync_reg);
                            mem_req_out <= 1'b1;
                            state_reg <= ST_WAIT;
                        end
                        K_TABLE:
                        begin
                            mem_addr_out <= idt_base_reg + {14'h0000, vec_off} +
                                {30'h00000000, mc_toff_next};
                            mem_req_out <= 1'b1;
                            state_reg <= ST_WAIT;
                        end
                        default:
                        begin
                            // Sequence complete: apply the control transfer.
                            state_reg <= ST_IDLE;
                            if (op == `RMASU_OP_NCALL || op == `RMASU_OP_FCALL)
                                instr_pointer_ext_reg <= tgt_off_reg;
                            if (op == `RMASU_OP_FCALL)
                                seg_reg[`RMASU_SEG_CS] <= tgt_seg_reg;
                            if (op == `RMASU_OP_INT)
                            begin
                                flags_ext_reg[`RMASU_FLAG_IF] <= 1'b0;
                                flags_ext_reg[`RMASU_FLAG_TF] <= 1'b0;
                                flags_ext_reg[`RMASU_FLAG_RF] <= 1'b0;
                                flags_ext_reg[`RMASU_FLAG_AC] <= 1'b0;
                            end
                        end
                    endcase
                end
                ST_WAIT:
                begin
                    if (mem_ack_in)
                    begin
                        mem_req_out <= 1'b0;
                        mem_we_out <= 1'b0;
                        step_reg <= step_reg + 3'h1;
                        state_reg <= ST_ISSUE;
                        if (kind_reg == K_POP)
                            gpr_reg[`RMASU_GPR_SP][15:0] <= sp_inc;
                        // Popped pointer clears the upper half.
                        if (kind_reg != K_PUSH && dst_reg == S_IP)
                            instr_pointer_ext_reg <= {16'h0000, mem_rdata_in};
                        else if (kind_reg != K_PUSH && dst_reg == S_CS)
                            seg_reg[`RMASU_SEG_CS] <= mem_rdata_in;
                        else if (kind_reg != K_PUSH)
                            flags_ext_reg[15:0] <= mem_rdata_in;
                    end
                end
                default: ;
            endcase
        end
    end

endmodule

//--- rtl/rmasu_map.vh
// Constants for the real-mode address and stack unit: register offsets,
// command codes, field positions, flag bits and reset values.
// Assumes inclusion by rmasu_core.v only; holds definitions alone.
`ifndef RMASU_MAP_VH
`define RMASU_MAP_VH

// Byte offsets on the register bus.
`define RMASU_OFF_CTRL 8'h00
`define RMASU_OFF_STATUS 8'h04
`define RMASU_OFF_EIP 8'h08
`define RMASU_OFF_FLAGS_EXT 8'h0C
`define RMASU_OFF_SEG 8'h10
`define RMASU_OFF_IDT_BASE 8'h28
`define RMASU_OFF_IDT_LIMIT 8'h2C
`define RMASU_OFF_XLAT_OFF 8'h30
`define RMASU_OFF_LINEAR 8'h34
`define RMASU_OFF_TGT_OFF 8'h38
`define RMASU_OFF_TGT_SEG 8'h3C
`define RMASU_OFF_GPR 8'h80

// Command codes in the control register.
`define RMASU_OP_NONE 4'h0
`define RMASU_OP_NCALL 4'h1
`define RMASU_OP_FCALL 4'h2
`define RMASU_OP_NRET 4'h3
`define RMASU_OP_FRET 4'h4
`define RMASU_OP_INT 4'h5
`define RMASU_OP_INT_RETURN_INSTR 4'h6
`define RMASU_OP_LOAD_INT_TABLE_BASE_INSTR 4'h7
`define RMASU_OP_XLAT 4'h8

// Control register fields.
`define RMASU_CTRL_OPSIZE 4
`define RMASU_CTRL_ADDRSIZE 5

// Segment selector indexes.
`define RMASU_SEG_CS 3'h0
`define RMASU_SEG_SS 3'h1

// Stack pointer is general register 4.
`define RMASU_GPR_SP 3'h4

// Flag bits cleared on handler entry.
`define RMASU_FLAG_TF 8
`define RMASU_FLAG_IF 9
`define RMASU_FLAG_RF 16
`define RMASU_FLAG_AC 18

// Reset values and fault vectors.
`define RMASU_RST_IDT_BASE 32'h00000000
`define RMASU_RST_IDT_LIMIT 16'h03FF
`define RMASU_RST_FLAGS_EXT 32'h00000002
`define RMASU_VEC_STACK_FAULT 8'h0C
`define RMASU_VEC_GP_FAULT 8'h0D

`endif

//--- bench/rmasu_props.sv
// Concurrent checks on the bus, memory and busy ports of the unit.
// Assumes one clock domain and the asynchronous active-low reset.
module rmasu_props (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [31:0] wb_dat_in,
    input wire wb_ack_out,
    input wire addr_bit20_mask_n_in,
    input wire mem_req_out,
    input wire mem_we_out,
    input wire [31:0] mem_addr_out,
    input wire mem_ack_in,
    input wire busy_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // A command is a taken control write with a nonzero code while idle.
    wire cmd_take = wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in &&
        wb_adr_in[7:2] == 6'h00 && wb_dat_in[3:0] != 4'h0 && !busy_out;
    ack_next_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("bus request not answered in one cycle");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("bus ack longer than one cycle");
    req_hold_a: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
        else $error("memory request dropped or changed early");
    req_drop_a: assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
        else $error("memory request kept after ack");
    req_busy_a: assert property (mem_req_out |-> busy_out)
        else $error("memory request outside a sequence");
    cmd_busy_a: assert property (cmd_take |=> busy_out)
        else $error("command did not start");
    xlat_time_a: assert property (cmd_take && wb_dat_in[3:0] == 4'h8 |=> busy_out ##[1:3] !busy_out)
        else $error("translate took too long");
    push_mask_a: assert property ($rose(mem_req_out) && mem_we_out && !$past(addr_bit20_mask_n_in, 2)
        && !$past(addr_bit20_mask_n_in, 3) && !$past(addr_bit20_mask_n_in, 4) |-> !mem_addr_out[20])
        else $error("address bit 20 not masked");
endmodule

//--- bench/rmasu_mem.sv
// Behavioural 16-bit memory answering the unit's request port.
// Assumes one request at a time, held until the ack pulse.
module rmasu_mem (
    input wire logic sys_clk_in,
    input wire logic mem_req_in,
    input wire logic mem_we_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [15:0] mem_wdata_in,
    output logic mem_ack_out = 1'b0,
    output logic [15:0] mem_rdata_out = 16'h0000
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [logic [31:0]];
    int cnt = 0;
    int slow = 0;
    // Latency alternates between one and three cycles; data toggles outside the answer.
    always @(posedge sys_clk_in)
    begin
        mem_ack_out <= 1'b0;
        mem_rdata_out <= ~mem_rdata_out;
        if (mem_req_in && !mem_ack_out)
        begin
            cnt = cnt + 1;
            if (cnt > slow)
            begin
                cnt = 0;
                slow = 2 - slow;
                mem_ack_out <= 1'b1;
                if (mem_we_in)
                    mem[mem_addr_in] = mem_wdata_in;
                else
                    mem_rdata_out <= mem.exists(mem_addr_in) ? mem[mem_addr_in] : 16'hDEAD;
            end
        end
    end
endmodule

//--- bench/real_mode_address_stack_unit_bench.sv
// Self-checking bench for the real-mode address and stack unit.
// Assumes the memory model sits on the unit's memory port.
module real_mode_address_stack_unit_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h00000000;
    logic mask_n = 1'b1;
    logic [31:0] rdat, maddr;
    logic ack, mreq, mwe, mack, busy;
    logic [15:0] mwd, mrd;
    int failures = 0;
    int checked = 0;
    // Address beside the value it should read after reset; 40 is unmapped.
    logic [39:0] rows [7] = '{40'h00_00000000, 40'h04_00000004, 40'h08_00000000,
        40'h0C_00000002, 40'h28_00000000, 40'h2C_000003FF, 40'h40_00000000};
    rmasu_core i_rmasu_core (.sys_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc),
        .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .addr_bit20_mask_n_in(mask_n), .mem_req_out(mreq),
        .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_ack_in(mack),
        .mem_rdata_in(mrd), .busy_out(busy));
    rmasu_mem i_rmasu_mem (.sys_clk_in(clk), .mem_req_in(mreq), .mem_we_in(mwe),
        .mem_addr_in(maddr), .mem_wdata_in(mwd), .mem_ack_out(mack), .mem_rdata_out(mrd));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    // Request is held until ack is sampled high, so no cycle length is assumed.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk iff ack === 1'b1);
        cyc <= 1'b0;
    endtask
    task automatic r(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(rdat, e);
    endtask
    task automatic c(input logic [31:0] d);
        bus(1'b1, 8'h00, d);
        @(posedge clk iff busy === 1'b0);
    endtask
    task automatic m(input logic [31:0] a, input logic [15:0] e);
        chk({16'h0000, i_rmasu_mem.mem[a]}, {16'h0000, e});
    endtask
    task automatic results;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Free-running clock at 125 MHz.
    initial
    begin
        forever #4 clk = ~clk;
    end
    // A hang counts as a mismatch; the tests need well under this span.
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        results;
    end
    // Reset table first, then sizing, translation, stack and table cases.
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
            r(rows[i][39:32], rows[i][31:0]);
        $display("reset test done");
        bus(1'b1, 8'h80, 32'h12345678);
        r(8'h80, 32'h00005678);
        bus(1'b1, 8'h00, 32'h00000010);
        bus(1'b1, 8'h80, 32'h12345678);
        r(8'h80, 32'h12345678);
        bus(1'b1, 8'h00, 32'h00000000);
        bus(1'b1, 8'h18, 32'h0000FFFF);
        bus(1'b1, 8'h30, 32'h0000FFFF);
        c(32'h00020008);
        r(8'h34, 32'h0010FFEF);
        mask_n <= 1'b0;
        repeat (3) @(posedge clk);
        c(32'h00020008);
        r(8'h34, 32'h0000FFEF);
        mask_n <= 1'b1;
        bus(1'b1, 8'h30, 32'h00010000);
        c(32'h00020028);
        r(8'h04, 32'h00000D06);
        r(8'h34, 32'h0000FFEF);
        bus(1'b1, 8'h04, 32'h00000002);
        c(32'h00010028);
        r(8'h04, 32'h00000C06);
        bus(1'b1, 8'h04, 32'h00000002);
        $display("translate test done");
        bus(1'b1, 8'h14, 32'h00001000);
        bus(1'b1, 8'h90, 32'h00000100);
        bus(1'b1, 8'h08, 32'h12345678);
        bus(1'b1, 8'h38, 32'h0000ABCD);
        c(32'h00000001);
        r(8'h90, 32'h000000FE);
        m(32'h000100FE, 16'h5678);
        r(8'h08, 32'h0000ABCD);
        c(32'h00000003);
        r(8'h08, 32'h00005678);
        bus(1'b1, 8'h10, 32'h00002222);
        bus(1'b1, 8'h3C, 32'h00003333);
        c(32'h00000002);
        m(32'h000100FE, 16'h2222);
        r(8'h10, 32'h00003333);
        c(32'h00000004);
        r(8'h10, 32'h00002222);
        r(8'h90, 32'h00000100);
        $display("call test done");
        i_rmasu_mem.mem[32'h0000000C] = 16'h4444;
        i_rmasu_mem.mem[32'h0000000E] = 16'h5555;
        bus(1'b1, 8'h0C, 32'h00040302);
        c(32'h00000305);
        m(32'h000100FE, 16'h0302);
        m(32'h000100FA, 16'h5678);
        r(8'h08, 32'h00004444);
        r(8'h10, 32'h00005555);
        r(8'h0C, 32'h00000002);
        c(32'h00000006);
        r(8'h10, 32'h00002222);
        r(8'h0C, 32'h00000302);
        bus(1'b1, 8'h38, 32'h00002000);
        bus(1'b1, 8'h3C, 32'h00000007);
        c(32'h00000007);
        r(8'h28, 32'h00002000);
        c(32'h00000205);
        r(8'h04, 32'h00000D06);
        $display("interrupt test done");
        results;
    end
endmodule
bind rmasu_core rmasu_props i_rmasu_props (.sys_clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in,
    .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_ack_out, .addr_bit20_mask_n_in, .mem_req_out,
    .mem_we_out, .mem_addr_out, .mem_ack_in, .busy_out);
